// ### hdl/pdm_pkg.sv
// Package of constants for the power-down mode controller
package pdm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PDM_OFS_CTRL1  = 8'h00;
    localparam logic [7:0] PDM_OFS_CTRL2  = 8'h04;
    localparam logic [7:0] PDM_OFS_HALT   = 8'h08;
    localparam logic [7:0] PDM_OFS_STATUS = 8'h0C;
    localparam logic [7:0] PDM_RST_CTRL1  = 8'h00;
    localparam logic [7:0] PDM_RST_CTRL2  = 8'h00;
    localparam logic [7:0] PDM_RST_HALT   = 8'h00;
    localparam logic [7:0] PDM_CTRL1_WMASK = 8'hF8;
    localparam logic [7:0] PDM_HALT_WMASK  = 8'h7F;
    // Control 1 fields
    localparam int PDM_STBY_BIT  = 7;
    localparam int PDM_WAIT_MSB  = 6;
    localparam int PDM_WAIT_LSB  = 4;
    localparam int PDM_NOISE_BIT = 3;
    // Control 2 fields
    localparam int PDM_SKIND_BIT = 7;
    localparam int PDM_LOWS_BIT  = 6;
    localparam int PDM_DIRT_BIT  = 5;
    localparam int PDM_MA_MSB    = 4;
    localparam int PDM_MA_LSB    = 2;
    localparam int PDM_SA_MSB    = 1;
    localparam int PDM_SA_LSB    = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PDM_NOISE_DIV_SLOW = 16;
    localparam int PDM_NOISE_DIV_FAST = 4;
    localparam int PDM_WAIT_W         = 18;
    localparam logic [17:0] PDM_WAIT_0 = 18'h02000;
    localparam logic [17:0] PDM_WAIT_1 = 18'h04000;
    localparam logic [17:0] PDM_WAIT_2 = 18'h08000;
    localparam logic [17:0] PDM_WAIT_3 = 18'h10000;
    localparam logic [17:0] PDM_WAIT_4 = 18'h20000;
    localparam logic [17:0] PDM_WAIT_5 = 18'h00400;
    localparam logic [17:0] PDM_WAIT_6 = 18'h00080;
    localparam logic [17:0] PDM_WAIT_7 = 18'h00010;
    typedef enum logic [2:0] {
        PDM_ACTIVE, PDM_SUBACTIVE, PDM_SLEEP, PDM_SUBSLEEP, PDM_STANDBY
    } pdm_mode_t;
endpackage

// ### hdl/pdm_clkdiv.sv
// Divider producing clock-enable ticks for the mode clocks
module pdm_clkdiv (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [6:0] ratio,
    output logic            tick
);
    logic [6:0] cnt_reg;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Count holds while stopped: edge-driven use would lose its phase if cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 7'h00;
        end else if (run && cnt_reg >= ratio - 7'h01) begin
            cnt_reg <= 7'h00;
        end else if (run) begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    assign tick = run && (cnt_reg >= ratio - 7'h01);
endmodule

// ### hdl/pdm_ctrl.sv
// Power-down mode controller with APB registers
//
// The address map and the APB register port were left to the implementer.
module pdm_ctrl #(
    parameter int NMOD = 7
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            sleep_exec,
    input  wire logic            wake_irq,
    input  wire logic            ext_clock_sel,
    input  wire logic            timebase_sel,
    input  wire logic            watch_clk_pin,
    output logic                 cpu_clk_en,
    output logic                 periph_clk_en,
    output logic [NMOD-1:0]      module_clk_en,
    output logic                 timebase_clk_en,
    output logic                 noise_sample_tick,
    output logic                 watch_clk_filtered,
    output logic                 wake_wait_busy
);
    logic [7:0]            ctrl1_reg;
    logic [7:0]            ctrl2_reg;
    logic [7:0]            halt_reg;
    pdm_pkg::pdm_mode_t    mode_reg;
    pdm_pkg::pdm_mode_t    mode_next;
    logic [17:0]           wait_reg;
    logic                  waiting_reg;
    logic [31:0]           prdata_reg;
    logic [2:0]            wclk_sync_reg;
    logic                  wclk_reg;
    logic                  sys_tick;
    logic                  sub_tick;
    logic                  noise_tick;
    logic [6:0]            sys_ratio;
    logic [6:0]            sub_ratio;
    logic                  wr_en;
    logic                  rd_en;
    logic                  addr_ok;
    logic                  sys_run;
    logic                  sub_side;
    logic                  wclk_prev_reg;
    logic [6:0]            sys_gap_reg;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // wait count table
    function automatic logic [17:0] wait_count(input logic [2:0] code);
        case (code)
            3'h0:    wait_count = pdm_pkg::PDM_WAIT_0;
            3'h1:    wait_count = pdm_pkg::PDM_WAIT_1;
            3'h2:    wait_count = pdm_pkg::PDM_WAIT_2;
            3'h3:    wait_count = pdm_pkg::PDM_WAIT_3;
            3'h4:    wait_count = pdm_pkg::PDM_WAIT_4;
            3'h5:    wait_count = pdm_pkg::PDM_WAIT_5;
            3'h6:    wait_count = pdm_pkg::PDM_WAIT_6;
            default: wait_count = pdm_pkg::PDM_WAIT_7;
        endcase
    endfunction

    function automatic logic is_sub(input pdm_pkg::pdm_mode_t m);
        is_sub = (m == pdm_pkg::PDM_SUBACTIVE) || (m == pdm_pkg::PDM_SUBSLEEP);
    endfunction

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign addr_ok = (paddr == pdm_pkg::PDM_OFS_CTRL1) || (paddr == pdm_pkg::PDM_OFS_CTRL2)
                  || (paddr == pdm_pkg::PDM_OFS_HALT) || (paddr == pdm_pkg::PDM_OFS_STATUS);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_reg <= pdm_pkg::PDM_RST_CTRL1;
        end else if (wr_en && paddr == pdm_pkg::PDM_OFS_CTRL1) begin
            ctrl1_reg <= pwdata[7:0] & pdm_pkg::PDM_CTRL1_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl2_reg <= pdm_pkg::PDM_RST_CTRL2;
        end else if (wr_en && paddr == pdm_pkg::PDM_OFS_CTRL2) begin
            ctrl2_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_reg <= pdm_pkg::PDM_RST_HALT;
        end else if (wr_en && paddr == pdm_pkg::PDM_OFS_HALT) begin
            halt_reg <= pwdata[7:0] & pdm_pkg::PDM_HALT_WMASK;
        end
    end

    // Read data captured in setup phase, valid during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                pdm_pkg::PDM_OFS_CTRL1:  prdata_reg <= {24'h000000, ctrl1_reg};
                pdm_pkg::PDM_OFS_CTRL2:  prdata_reg <= {24'h000000, ctrl2_reg};
                pdm_pkg::PDM_OFS_HALT:   prdata_reg <= {24'h000000, halt_reg};
                pdm_pkg::PDM_OFS_STATUS: prdata_reg <= {28'h0000000, waiting_reg, mode_reg};
                default:                 prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        if (sleep_exec && !waiting_reg) begin
            if (ctrl1_reg[pdm_pkg::PDM_STBY_BIT]) begin
                mode_next = pdm_pkg::PDM_STANDBY;
            end else if (ctrl2_reg[pdm_pkg::PDM_DIRT_BIT]) begin
                mode_next = ctrl2_reg[pdm_pkg::PDM_LOWS_BIT] ? pdm_pkg::PDM_SUBACTIVE : pdm_pkg::PDM_ACTIVE;
            end else if (ctrl2_reg[pdm_pkg::PDM_SKIND_BIT] && ctrl2_reg[pdm_pkg::PDM_LOWS_BIT]) begin
                mode_next = pdm_pkg::PDM_SUBSLEEP;
            end else begin
                mode_next = pdm_pkg::PDM_SLEEP;
            end
        end else if (wake_irq && mode_reg != pdm_pkg::PDM_ACTIVE) begin
            mode_next = ctrl2_reg[pdm_pkg::PDM_LOWS_BIT] ? pdm_pkg::PDM_SUBACTIVE : pdm_pkg::PDM_ACTIVE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= pdm_pkg::PDM_ACTIVE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // Wake wait counter
    // ------------------------------------------------------------
    // wait on wake into system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waiting_reg <= 1'b0;
            wait_reg    <= 18'h00000;
        end else if (mode_next != mode_reg && !is_sub(mode_next)
                     && (mode_reg == pdm_pkg::PDM_STANDBY || is_sub(mode_reg))) begin
            waiting_reg <= 1'b1;
            wait_reg    <= wait_count(ctrl1_reg[pdm_pkg::PDM_WAIT_MSB:pdm_pkg::PDM_WAIT_LSB]) - 18'h00001;
        end else if (waiting_reg) begin
            if (wait_reg == 18'h00000) begin
                waiting_reg <= 1'b0;
            end else begin
                wait_reg <= wait_reg - 18'h00001;
            end
        end
    end

    assign wake_wait_busy = waiting_reg;

    // ------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------
    // system divider ratio
    always_comb begin
        case (ctrl2_reg[pdm_pkg::PDM_MA_MSB:pdm_pkg::PDM_MA_LSB])
            3'h4:    sys_ratio = 7'h08;
            3'h5:    sys_ratio = 7'h10;
            3'h6:    sys_ratio = 7'h20;
            3'h7:    sys_ratio = 7'h40;
            default: sys_ratio = 7'h01;
        endcase
    end

    always_comb begin
        case (ctrl2_reg[pdm_pkg::PDM_SA_MSB:pdm_pkg::PDM_SA_LSB])
            2'h0:    sub_ratio = 7'h02;
            2'h1:    sub_ratio = 7'h04;
            default: sub_ratio = 7'h08;
        endcase
    end

    assign sub_side = is_sub(mode_reg);
    assign sys_run  = !sub_side && mode_reg != pdm_pkg::PDM_STANDBY && !waiting_reg;

    pdm_clkdiv u_sys_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (sys_run),
        .ratio   (sys_ratio),
        .tick    (sys_tick)
    );

    // Subclock counts rising edges of the filtered watch clock
    pdm_clkdiv u_sub_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (sub_side && wclk_reg && !wclk_prev_reg),
        .ratio   (sub_ratio),
        .tick    (sub_tick)
    );

    // ------------------------------------------------------------
    // Watch clock sampling
    // ------------------------------------------------------------
    // sampling rate select
    pdm_clkdiv u_noise_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (1'b1),
        .ratio   (ctrl1_reg[pdm_pkg::PDM_NOISE_BIT] ? 7'(pdm_pkg::PDM_NOISE_DIV_FAST)
                                                    : 7'(pdm_pkg::PDM_NOISE_DIV_SLOW)),
        .tick    (noise_tick)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclk_sync_reg <= 3'h0;
        end else begin
            wclk_sync_reg <= {wclk_sync_reg[1:0], watch_clk_pin};
        end
    end

    // Only accepted when stages two and three agree on a sample tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclk_reg <= 1'b0;
        end else if (noise_tick && wclk_sync_reg[1] == wclk_sync_reg[2]) begin
            wclk_reg <= wclk_sync_reg[2];
        end
    end

    // Previous filtered level, for the rising-edge pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclk_prev_reg <= 1'b0;
        end else begin
            wclk_prev_reg <= wclk_reg;
        end
    end

    assign noise_sample_tick  = noise_tick;
    assign watch_clk_filtered = wclk_reg;

    // ------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------
    // processor enable
    assign cpu_clk_en    = (mode_reg == pdm_pkg::PDM_ACTIVE && sys_tick)
                        || (mode_reg == pdm_pkg::PDM_SUBACTIVE && sub_tick);
    assign periph_clk_en = sub_side ? sub_tick : sys_tick;
    assign timebase_clk_en = timebase_sel ? wclk_reg : periph_clk_en;

    genvar gi;
    generate
        for (gi = 0; gi < NMOD; gi++) begin : g_mod
            assign module_clk_en[gi] = periph_clk_en && !halt_reg[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic unused_ext;
    assign unused_ext = ext_clock_sel;

    // Cycles since the last system tick, for the divider check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_gap_reg <= 7'h00;
        end else if (sys_tick) begin
            sys_gap_reg <= 7'h00;
        end else if (sys_gap_reg != 7'h7F) begin
            sys_gap_reg <= sys_gap_reg + 7'h01;
        end
    end

    standby_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == pdm_pkg::PDM_STANDBY |-> !cpu_clk_en && !periph_clk_en)
        else $error("clock running in standby");
    sleep_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == pdm_pkg::PDM_SLEEP |-> !cpu_clk_en)
        else $error("cpu running in sleep");
    subsleep_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == pdm_pkg::PDM_SUBSLEEP |-> !cpu_clk_en)
        else $error("cpu running in subsleep");
    standby_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_exec && !waiting_reg && ctrl1_reg[7] |=> mode_reg == pdm_pkg::PDM_STANDBY)
        else $error("standby not entered");
    sleep_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_exec && !waiting_reg && ctrl1_reg[7:5] == 3'h0 && !ctrl2_reg[5] && !ctrl2_reg[6]
        |=> mode_reg == pdm_pkg::PDM_SLEEP)
        else $error("sleep not entered");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl1_reg[2:0] == 3'h0)
        else $error("reserved bits set");
    wait_short_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(waiting_reg) && ctrl1_reg[6:4] == 3'h7 |-> ##15 (waiting_reg && wait_reg == 18'h00000) ##1 !waiting_reg)
        else $error("16 state wait wrong");
    wait_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        waiting_reg |-> !cpu_clk_en && !periph_clk_en)
        else $error("clock during wake wait");
    module_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        halt_reg[0] |-> !module_clk_en[0])
        else $error("halted module clocked");
    noise_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
        noise_tick && ctrl1_reg[3] ##1 ctrl1_reg[3] [*4]
        |-> noise_tick && $past(!noise_tick) && $past(!noise_tick, 2) && $past(!noise_tick, 3))
        else $error("noise rate wrong");
    div8_a: assert property (@(posedge pclk) disable iff (!presetn)
        sys_tick && sys_ratio == 7'h08 ##1 (sys_run && sys_ratio == 7'h08) [*8] |-> sys_tick && sys_gap_reg == 7'h07)
        else $error("divide by 8 wrong");

    cov_standby_c: cover property (@(posedge pclk) mode_reg == pdm_pkg::PDM_STANDBY);
    cov_wake_c: cover property (@(posedge pclk) $fell(waiting_reg));
    cov_subact_c: cover property (@(posedge pclk) mode_reg == pdm_pkg::PDM_SUBACTIVE && cpu_clk_en);
endmodule

// ### test/power_down_mode_control_bench.sv
// Self-checking bench for the power-down mode controller
module power_down_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep_exec;
    logic        wake_irq;
    logic        ext_clock_sel;
    logic        timebase_sel;
    logic        watch_clk_pin;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic [6:0]  module_clk_en;
    logic        timebase_clk_en;
    logic        noise_sample_tick;
    logic        watch_clk_filtered;
    logic        wake_wait_busy;
    int          mismatches;
    int          cmp_count;
    logic [31:0] rd;
    logic        err;

    pdm_ctrl #(.NMOD(7)) pdm_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .wake_irq(wake_irq), .ext_clock_sel(ext_clock_sel),
        .timebase_sel(timebase_sel), .watch_clk_pin(watch_clk_pin), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .module_clk_en(module_clk_en), .timebase_clk_en(timebase_clk_en),
        .noise_sample_tick(noise_sample_tick), .watch_clk_filtered(watch_clk_filtered),
        .wake_wait_busy(wake_wait_busy)
    );

    // ------------------------------------------------------------
    // Clock, watch clock and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; sleep_exec = 1'b0; wake_irq = 1'b0;
        ext_clock_sel = 1'b0; timebase_sel = 1'b0; watch_clk_pin = 1'b0;
        mismatches = 0; cmp_count = 0;
    end
    always #5 pclk = ~pclk;
    // Slow watch clock, toggled every 15 bus clock cycles
    always begin
        repeat (15) @(posedge pclk);
        watch_clk_pin <= ~watch_clk_pin;
    end
    initial begin
        #400000;
        mismatches++;
        summarize();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Waits for pready, so any slave latency is tolerated
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse_sleep();
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
    endtask

    // Counts how many cycles out of len a sampled output was high
    task automatic count_high(input int sel, input int len, output int cnt);
        cnt = 0;
        repeat (len) begin
            @(posedge pclk);
            #1;
            case (sel)
                0: cnt += int'(cpu_clk_en);
                1: cnt += int'(periph_clk_en);
                2: cnt += int'(noise_sample_tick);
                3: cnt += int'(module_clk_en[0]);
                default: cnt += int'(module_clk_en[1]);
            endcase
        end
    endtask

    // Wakes the core and measures the busy span; enables stay off during it
    task automatic wake_measure(output int span);
        span = 0;
        @(posedge pclk);
        wake_irq <= 1'b1;
        @(posedge pclk);
        wake_irq <= 1'b0;
        #1;
        while (wake_wait_busy === 1'b1 && span < 20000) begin
            span++;
            if (cpu_clk_en !== 1'b0 || periph_clk_en !== 1'b0)
                check({30'h0, cpu_clk_en, periph_clk_en}, 32'h0);
            @(posedge pclk);
            #1;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_registers();
        apb(1'b0, pdm_pkg::PDM_OFS_CTRL1, 32'h0); check(rd, 32'h0);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL1, 32'hFFFF_FFFF);
        apb(1'b0, pdm_pkg::PDM_OFS_CTRL1, 32'h0); check(rd, 32'h0000_00F8);
        apb(1'b1, pdm_pkg::PDM_OFS_HALT, 32'h0000_00FF);
        apb(1'b0, pdm_pkg::PDM_OFS_HALT, 32'h0); check(rd, 32'h0000_007F);
        apb(1'b1, 8'h40, 32'h0000_00AA); check({31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0); check(rd, 32'h0);
        apb(1'b1, pdm_pkg::PDM_OFS_HALT, 32'h0);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL1, 32'h0);
    endtask

    task automatic t_noise();
        int c;
        count_high(2, 64, c); check(32'(c), 32'd4);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL1, 32'h0000_0008);
        count_high(2, 64, c); check(32'(c), 32'd16);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL1, 32'h0);
    endtask

    task automatic t_module_halt();
        int c;
        apb(1'b1, pdm_pkg::PDM_OFS_HALT, 32'h0000_0001);
        count_high(3, 16, c); check(32'(c), 32'd0);
        count_high(4, 16, c); check(32'(c), 32'd16);
        apb(1'b1, pdm_pkg::PDM_OFS_HALT, 32'h0);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL2, 32'h0000_0010);
        count_high(0, 64, c); check(32'(c), 32'd8);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL2, 32'h0);
    endtask

    // Between two processor ticks in subactive, two filtered watch clock rises
    task automatic t_subactive();
        int   rises;
        int   n;
        logic prev_lvl;
        rises = 0;
        n = 0;
        @(posedge pclk);
        #1;
        while (cpu_clk_en !== 1'b1 && n < 400) begin
            @(posedge pclk);
            #1;
            n++;
        end
        prev_lvl = watch_clk_filtered;
        do begin
            @(posedge pclk);
            #1;
            n++;
            if (watch_clk_filtered === 1'b1 && prev_lvl === 1'b0)
                rises++;
            prev_lvl = watch_clk_filtered;
        end while (cpu_clk_en !== 1'b1 && n < 400);
        check(32'(rises), 32'd2);
    endtask

    task automatic t_sleep();
        int c;
        pulse_sleep();
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_SLEEP));
        count_high(0, 16, c); check(32'(c), 32'd0);
        count_high(1, 16, c); check(32'(c), 32'd16);
        wake_measure(c); check(32'(c), 32'd0);
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_ACTIVE));
    endtask

    task automatic t_standby(input logic [2:0] code, input int exp_wait);
        int c;
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL1, {24'h0, 1'b1, code, 4'h0});
        pulse_sleep();
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_STANDBY));
        count_high(0, 16, c); check(32'(c), 32'd0);
        count_high(1, 16, c); check(32'(c), 32'd0);
        timebase_sel <= 1'b1;
        repeat (40) begin
            @(posedge pclk);
            #1;
            if (timebase_clk_en !== watch_clk_filtered)
                check({31'h0, timebase_clk_en}, {31'h0, watch_clk_filtered});
        end
        timebase_sel <= 1'b0;
        wake_measure(c); check(32'(c), 32'(exp_wait));
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_ACTIVE));
    endtask

    task automatic t_subsleep();
        int c;
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL1, 32'h0);
        apb(1'b1, pdm_pkg::PDM_OFS_CTRL2, 32'h0000_00C0);
        pulse_sleep();
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_SUBSLEEP));
        count_high(0, 64, c); check(32'(c), 32'd0);
        wake_measure(c); check(32'(c), 32'd0);
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_SUBACTIVE));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_registers();
        t_noise();
        t_module_halt();
        t_sleep();
        t_standby(3'h7, 16);
        t_standby(3'h6, 128);
        t_subsleep();
        t_subactive();
        // Reset in mid-run must bring back active mode and cleared registers
        do_reset();
        apb(1'b0, pdm_pkg::PDM_OFS_STATUS, 32'h0); check(rd, 32'(pdm_pkg::PDM_ACTIVE));
        apb(1'b0, pdm_pkg::PDM_OFS_CTRL2, 32'h0); check(rd, 32'h0);
        t_standby(3'h5, 1024);
        summarize();
    end
endmodule
